// *** design/flash_pd_sequencer.sv ***
// suspend/resume codes, deep power-down control and busy polling of a serial flash
// Operation
// - word 13 bits 31:24 carry the general suspend command code.
// - word 13 bits 23:16 carry the general resume command code.
// - word 13 bits 15:8 carry the program suspend code, or the general one if none differs.
// - word 13 bits 7:0 carry the program resume code, or the general one if none differs.
// - word 14 bit 31 is zero when power-down is supported; when one, no power-down is done.
// - word 14 bits 30:23 carry the enter power-down command code.
// - word 14 bits 22:15 carry the exit power-down command code.
// - word 14 bits 7:2 are polling capability flags, zero meaning unsupported.
// - with the flag capability, command 70h returns bit 7 zero while busy, one when ready.
// - with the flag capability, flag polling is allowed any time the device is busy; the code answers it only in the active power state.
// - with the legacy capability, command 05h returns bit 0 one while busy, zero when ready.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module flash_pd_sequencer
   import flash_pd_pkg::*;
#(
   parameter logic [7:0]        SUSPEND_CODE       = 8'hA1,
   parameter logic [7:0]        RESUME_CODE        = 8'hA2,
   parameter logic [7:0]        PROG_SUSPEND_CODE  = 8'hA1,
   parameter logic [7:0]        PROG_RESUME_CODE   = 8'hA2,
   parameter logic [7:0]        ENTER_PD_CODE      = 8'hA3,
   parameter logic [7:0]        EXIT_PD_CODE       = 8'hA4,
   parameter logic [UNIT_W-1:0] UNIT3_CYCLES       = UNIT_W'(UNIT3_CYCLES_DEF)
)(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire cmd_t        cmd_i,
   input  wire logic        op_busy_i,
   output rsp_t             rsp_o,
   output logic             cmd_ignored_o,
   output logic             write_in_progress_flag_o,
   output logic             powered_down_o,
   output logic             exiting_o,
   output logic             suspended_o,
   output logic             prog_suspended_o
);
   main_state_t s;
   main_state_t next_s;

   logic [31:0]        word13;
   logic [31:0]        word14;
   logic [31:0]        state_word;
   logic [31:0]        rd_word;
   logic [UNIT_W-1:0]  unit_sel;
   logic [1:0]         cfg_unit;
   logic [COUNT_W-1:0] cfg_count;
   logic [CAPS_W-1:0]  cfg_caps;
   logic               pd_unsup;
   logic               busy;
   logic               tmr_start;
   logic               tmr_busy;
   logic               addr_acc;
   logic               mapped;
   logic               is_cmd;

   assign cfg_unit  = s.cfg[CFG_UNIT_LSB +: 2];
   assign cfg_count = s.cfg[CFG_COUNT_LSB +: COUNT_W];
   assign cfg_caps  = s.cfg[CFG_CAPS_LSB +: CAPS_W];
   assign pd_unsup  = s.cfg[CFG_PD_UNSUP_BIT];
   // a suspended operation makes no progress, so it does not count as busy
   assign busy      = op_busy_i & ~s.susp & ~s.prog_susp;
   assign is_cmd    = cmd_i.valid;

   assign word13 = {SUSPEND_CODE, RESUME_CODE, PROG_SUSPEND_CODE, PROG_RESUME_CODE};
   assign word14 = {pd_unsup, ENTER_PD_CODE, EXIT_PD_CODE, cfg_unit, cfg_count, cfg_caps,
                    W14_RESERVED};
   assign state_word = {26'h0, busy, s.pwr == PWR_EXITING, s.pwr == PWR_DOWN,
                        s.prog_susp, s.susp, op_busy_i};

   always_comb begin
      case (cfg_unit)
         2'h0:    unit_sel = UNIT0_CYCLES;
         2'h1:    unit_sel = UNIT1_CYCLES;
         2'h2:    unit_sel = UNIT2_CYCLES;
         default: unit_sel = UNIT3_CYCLES;
      endcase
   end

   assign addr_acc = hsel_i & htrans_i[1] & hready_i;
   assign mapped   = (haddr_i[31:4] == 28'h0);

   always_comb begin
      if (!mapped) begin
         rd_word = 32'h0;
      end else begin
         case (haddr_i[3:0])
            OFF_WORD13: rd_word = word13;
            OFF_WORD14: rd_word = word14;
            OFF_CONFIG: rd_word = {18'h0, s.cfg};
            OFF_STATE:  rd_word = state_word;
            default:    rd_word = 32'h0;
         endcase
      end
   end

   always_comb begin
      next_s         = s;
      next_s.rsp     = '0;
      next_s.ignored = 1'b0;
      tmr_start      = 1'b0;

      // bus: read data sampled in address phase, write lands in data phase
      next_s.wr_pend = addr_acc & hwrite_i & mapped;
      next_s.wr_addr = haddr_i[3:0];
      if (addr_acc && !hwrite_i) begin
         next_s.rdata = rd_word;
      end
      if (s.wr_pend && s.wr_addr == OFF_CONFIG) begin
         next_s.cfg = hwdata_i[CFG_W-1:0];
      end

      case (s.pwr)
         PWR_ACTIVE: begin
            if (is_cmd) begin
               if (cmd_i.code == CMD_READ_STATUS) begin
                  if (cfg_caps[CAP_LEGACY_BIT]) begin
                     next_s.rsp.valid = 1'b1;
                     next_s.rsp.data  = 8'h00;
                     next_s.rsp.data[STATUS_WIP_BIT] = busy;
                  end else begin
                     next_s.ignored = 1'b1;
                  end
               end else if (cmd_i.code == CMD_READ_FLAG) begin
                  if (cfg_caps[CAP_FLAG_BIT]) begin
                     next_s.rsp.valid = 1'b1;
                     next_s.rsp.data  = 8'h00;
                     next_s.rsp.data[FLAG_READY_BIT] = ~busy;
                  end else begin
                     next_s.ignored = 1'b1;
                  end
               end else if (cmd_i.code == SUSPEND_CODE) begin
                  if (op_busy_i) begin
                     next_s.susp = 1'b1;
                  end
               end else if (cmd_i.code == RESUME_CODE) begin
                  next_s.susp = 1'b0;
               end else if (cmd_i.code == PROG_SUSPEND_CODE) begin
                  if (op_busy_i) begin
                     next_s.prog_susp = 1'b1;
                  end
               end else if (cmd_i.code == PROG_RESUME_CODE) begin
                  next_s.prog_susp = 1'b0;
               end else if (cmd_i.code == ENTER_PD_CODE) begin
                  // never power down while an operation is busy and not suspended
                  if (!pd_unsup && !busy) begin
                     next_s.pwr = PWR_DOWN;
                  end else begin
                     next_s.ignored = 1'b1;
                  end
               end
            end
         end
         PWR_DOWN: begin
            if (is_cmd) begin
               if (cmd_i.code == EXIT_PD_CODE) begin
                  next_s.pwr = PWR_EXITING;
                  tmr_start  = 1'b1;
               end else begin
                  next_s.ignored = 1'b1;
               end
            end
         end
         PWR_EXITING: begin
            // status is meaningless while waking; host must wait the delay
            if (is_cmd) begin
               next_s.ignored = 1'b1;
            end
            if (!tmr_busy) begin
               next_s.pwr = PWR_ACTIVE;
            end
         end
         default: begin
            next_s.pwr = PWR_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s     <= '0;
         s.pwr <= PWR_ACTIVE;
         s.cfg <= CFG_RESET;
      end else begin
         s <= next_s;
      end
   end

   exit_delay_timer u_exit_timer (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .start_i       (tmr_start),
      .unit_cycles_i (unit_sel),
      .count_i       (cfg_count),
      .busy_o        (tmr_busy)
   );

   assign hrdata_o                 = s.rdata;
   assign hreadyout_o              = 1'b1;
   assign hresp_o                  = 1'b0;
   assign rsp_o                    = s.rsp;
   assign cmd_ignored_o            = s.ignored;
   assign write_in_progress_flag_o = busy;
   assign powered_down_o           = (s.pwr == PWR_DOWN);
   assign exiting_o                = (s.pwr == PWR_EXITING);
   assign suspended_o              = s.susp;
   assign prog_suspended_o         = s.prog_susp;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   logic rd13;
   logic rd14;
   assign rd13 = addr_acc && !hwrite_i && haddr_i == {28'h0, OFF_WORD13};
   assign rd14 = addr_acc && !hwrite_i && haddr_i == {28'h0, OFF_WORD14};

   a_suspend_codes: assert property (rd13 |=>
      hrdata_o[W13_SUSPEND_LSB +: 8] == SUSPEND_CODE) else $error("suspend code wrong");
   a_resume_codes: assert property (rd13 |=>
      hrdata_o[W13_RESUME_LSB +: 8] == RESUME_CODE) else $error("resume code wrong");
   a_prog_suspend_code: assert property (rd13 |=>
      hrdata_o[W13_PSUSPEND_LSB +: 8] == PROG_SUSPEND_CODE) else $error("prog suspend wrong");
   a_prog_resume_code: assert property (rd13 |=>
      hrdata_o[W13_PRESUME_LSB +: 8] == PROG_RESUME_CODE) else $error("prog resume wrong");
   a_pd_codes_out: assert property (rd14 |=>
      hrdata_o[W14_ENTER_LSB +: 8] == ENTER_PD_CODE && hrdata_o[W14_EXIT_LSB +: 8] == EXIT_PD_CODE
      && hrdata_o[1:0] == W14_RESERVED) else $error("power-down codes wrong");
   a_caps_field_out: assert property (rd14 && !s.wr_pend |=>
      hrdata_o[W14_CAPS_LSB +: CAPS_W] == $past(cfg_caps)) else $error("caps field wrong");
   a_pd_refused_unsup: assert property (
      s.pwr == PWR_ACTIVE && is_cmd && cmd_i.code == ENTER_PD_CODE && pd_unsup
      |=> !powered_down_o && cmd_ignored_o) else $error("power-down taken while unsupported");

   sequence exit_taken;
      s.pwr == PWR_DOWN && is_cmd && cmd_i.code == EXIT_PD_CODE;
   endsequence
   sequence waking_min;
      exiting_o [*8];
   endsequence
   a_exit_wait_held: assert property (exit_taken |=> waking_min)
      else $error("exit delay cut short");
   a_wake_no_status: assert property (exiting_o && is_cmd |=>
      cmd_ignored_o && !rsp_o.valid) else $error("status answered while waking");
   a_flag_busy_read: assert property (
      s.pwr == PWR_ACTIVE && is_cmd && cmd_i.code == CMD_READ_FLAG && cfg_caps[CAP_FLAG_BIT]
      |=> rsp_o.valid && rsp_o.data[FLAG_READY_BIT] == !$past(busy)) else $error("flag read bad");
   a_legacy_busy_read: assert property (
      s.pwr == PWR_ACTIVE && is_cmd && cmd_i.code == CMD_READ_STATUS && cfg_caps[CAP_LEGACY_BIT]
      |=> rsp_o.valid && rsp_o.data[STATUS_WIP_BIT] == $past(busy)) else $error("status read bad");
endmodule

// *** common/flash_pd_pkg.sv ***
// constants, field layout and carrier types of the suspend / power-down parameter block
package flash_pd_pkg;
   // clock and delay units
   localparam int CLK_PERIOD_NS = 8;
   localparam int UNIT0_NS      = 128;
   localparam int UNIT1_NS      = 1000;
   localparam int UNIT2_NS      = 8000;
   localparam int UNIT3_NS      = 64000;
   localparam int UNIT_W        = 14;
   localparam logic [UNIT_W-1:0] UNIT0_CYCLES = UNIT_W'(UNIT0_NS / CLK_PERIOD_NS);
   localparam logic [UNIT_W-1:0] UNIT1_CYCLES = UNIT_W'(UNIT1_NS / CLK_PERIOD_NS);
   localparam logic [UNIT_W-1:0] UNIT2_CYCLES = UNIT_W'(UNIT2_NS / CLK_PERIOD_NS);
   localparam int UNIT3_CYCLES_DEF = UNIT3_NS / CLK_PERIOD_NS;
   localparam int COUNT_W = 5;

   // register byte offsets
   localparam logic [3:0] OFF_WORD13 = 4'h0;
   localparam logic [3:0] OFF_WORD14 = 4'h4;
   localparam logic [3:0] OFF_CONFIG = 4'h8;
   localparam logic [3:0] OFF_STATE  = 4'hC;

   // parameter word fields
   localparam int W13_SUSPEND_LSB   = 24;
   localparam int W13_RESUME_LSB    = 16;
   localparam int W13_PSUSPEND_LSB  = 8;
   localparam int W13_PRESUME_LSB   = 0;
   localparam int W14_PD_UNSUP_BIT  = 31;
   localparam int W14_ENTER_LSB     = 23;
   localparam int W14_EXIT_LSB      = 15;
   localparam int W14_UNIT_LSB      = 13;
   localparam int W14_COUNT_LSB     = 8;
   localparam int W14_CAPS_LSB      = 2;
   localparam logic [1:0] W14_RESERVED = 2'h0;

   // config register layout
   localparam int CFG_W            = 14;
   localparam int CFG_PD_UNSUP_BIT = 0;
   localparam int CFG_UNIT_LSB     = 1;
   localparam int CFG_COUNT_LSB    = 3;
   localparam int CFG_CAPS_LSB     = 8;
   localparam int CAPS_W           = 6;
   localparam logic [CFG_W-1:0] CFG_RESET = 14'h0324;
   localparam int CAP_LEGACY_BIT   = 0;
   localparam int CAP_FLAG_BIT     = 1;

   // status command codes and bit positions
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   localparam logic [7:0] CMD_READ_FLAG   = 8'h70;
   localparam int STATUS_WIP_BIT = 0;
   localparam int FLAG_READY_BIT = 7;

   typedef enum logic [2:0] {
      PWR_ACTIVE  = 3'b001,
      PWR_DOWN    = 3'b010,
      PWR_EXITING = 3'b100
   } pwr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } cmd_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rsp_t;

   typedef struct packed {
      pwr_t             pwr;
      logic             susp;
      logic             prog_susp;
      logic [CFG_W-1:0] cfg;
      logic [31:0]      rdata;
      logic             wr_pend;
      logic [3:0]       wr_addr;
      rsp_t             rsp;
      logic             ignored;
   } main_state_t;

   typedef struct packed {
      logic [UNIT_W-1:0]  prescale;
      logic [UNIT_W-1:0]  unit;
      logic [COUNT_W-1:0] remaining;
      logic               running;
   } timer_state_t;
endpackage

// *** design/exit_delay_timer.sv ***
// counts (count+1) units of a selectable cycle length
`timescale 1ns/100ps
module exit_delay_timer
   import flash_pd_pkg::*;
(
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire logic               start_i,
   input  wire logic [UNIT_W-1:0]  unit_cycles_i,
   input  wire logic [COUNT_W-1:0] count_i,
   output logic                    busy_o
);
   timer_state_t s;
   timer_state_t next_s;

   always_comb begin
      next_s = s;
      if (start_i) begin
         next_s.running   = 1'b1;
         next_s.unit      = unit_cycles_i;
         next_s.prescale  = unit_cycles_i - UNIT_W'(1);
         next_s.remaining = count_i;
      end else if (s.running) begin
         if (s.prescale == '0) begin
            if (s.remaining == '0) begin
               next_s.running = 1'b0;
            end else begin
               next_s.remaining = s.remaining - COUNT_W'(1);
               next_s.prescale  = s.unit - UNIT_W'(1);
            end
         end else begin
            next_s.prescale = s.prescale - UNIT_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy_o = s.running;
endmodule

// *** dv/flash_host_model.sv ***
// host-side command issuer that keeps the power-down exit wait
`timescale 1ns/100ps
module flash_host_model
   import flash_pd_pkg::*;
#(
   parameter int UNIT3 = 40
)(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       go_i,
   input  wire logic [7:0] code_i,
   input  wire logic [7:0] exit_code_i,
   input  wire logic [1:0] unit_i,
   input  wire logic [4:0] count_i,
   output cmd_t            cmd_o,
   output logic            ready_o
);
   int hold;
   int unit_cyc;
   always_comb begin
      case (unit_i)
         2'h0: unit_cyc = 16;
         2'h1: unit_cyc = 125;
         2'h2: unit_cyc = 1000;
         default: unit_cyc = UNIT3;
      endcase
   end
   // no status polling while leaving power-down, only the timed wait
   assign ready_o = (hold == 0);
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cmd_o <= '0;
         hold  <= 0;
      end else begin
         // idle code toggles so a stale value never looks valid
         cmd_o <= '{valid: go_i, code: go_i ? code_i : ~cmd_o.code};
         // reserved capability bits are never read here
         if (go_i && code_i == exit_code_i) begin
            hold <= (int'(count_i) + 1) * unit_cyc + 2;
         end else if (hold != 0) begin
            hold <= hold - 1;
         end
      end
   end
endmodule

// *** dv/flash_suspend_powerdown_params_bench.sv ***
// self-checking bench of the suspend / power-down sequencer
`timescale 1ns/100ps
module flash_suspend_powerdown_params_bench;
   import flash_pd_pkg::*;
   localparam int U3 = 40;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic        hsel = 1'b0;
   logic [2:0]  hsize = 3'h0;
   logic [7:0]  exit_code = 8'hB6;
   logic        op_busy = 1'b0;
   logic        go = 1'b0;
   logic [7:0]  code = '0;
   logic [1:0]  m_unit = 2'h2;
   logic [4:0]  m_count = 5'h04;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   cmd_t        cmd;
   rsp_t        rsp;
   logic        ign, write_in_progress_flag, pdn, exiting, susp, psusp, h_ready;
   int          ex_cnt = 0;
   int          fail_count = 0;
   int          n_tests = 0;

   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) if (exiting === 1'b1) ex_cnt++;

   flash_host_model #(.UNIT3(U3)) host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .go_i(go),
      .code_i(code), .exit_code_i(exit_code), .unit_i(m_unit), .count_i(m_count), .cmd_o(cmd),
      .ready_o(h_ready));
   flash_pd_sequencer #(.SUSPEND_CODE(8'hB1), .RESUME_CODE(8'hB2), .PROG_SUSPEND_CODE(8'hB3),
      .PROG_RESUME_CODE(8'hB4), .ENTER_PD_CODE(8'hB5), .EXIT_PD_CODE(8'hB6),
      .UNIT3_CYCLES(UNIT_W'(U3))) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .cmd_i(cmd), .op_busy_i(op_busy), .rsp_o(rsp), .cmd_ignored_o(ign),
      .write_in_progress_flag_o(write_in_progress_flag), .powered_down_o(pdn), .exiting_o(exiting),
      .suspended_o(susp), .prog_suspended_o(psusp));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] d);
      @(posedge ref_clk_i);
      haddr <= a;
      hwrite <= w;
      hsel <= 1'b1;
      hsize <= 3'h2;
      htrans <= 2'h2;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      d = hrdata;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      ahb(a, 1'b0, 32'h0, d);
      check(d, exp);
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic set_cfg(input logic uns, input logic [1:0] u, input logic [4:0] c,
                          input logic [5:0] caps);
      logic [31:0] d;
      ahb(32'h8, 1'b1, {18'h0, caps, c, u, uns}, d);
      m_unit <= u;
      m_count <= c;
   endtask
   task automatic send(input logic [7:0] c, input bit w);
      int k;
      k = 0;
      while (w && h_ready !== 1'b1 && k < 5000) begin
         @(posedge ref_clk_i);
         k++;
      end
      @(posedge ref_clk_i);
      go <= 1'b1;
      code <= c;
      @(posedge ref_clk_i);
      go <= 1'b0;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic t_codes;
      logic [31:0] d;
      rd_chk(32'h0, 32'hB1B2B3B4);
      rd_chk(32'h4, {1'b0, 8'hB5, 8'hB6, 2'h2, 5'h04, 6'h03, 2'h0});
      rd_chk(32'h8, 32'h324);
      ahb(32'h0, 1'b1, 32'hFFFFFFFF, d);
      rd_chk(32'h0, 32'hB1B2B3B4);
      rd_chk(32'h10, 32'h0);
      $display("test codes done");
   endtask
   task automatic t_poll;
      for (int b = 0; b < 2; b++) begin
         @(posedge ref_clk_i);
         op_busy <= b[0];
         send(CMD_READ_STATUS, 1'b1);
         check({rsp.valid, rsp.data[0], ign}, {2'b11 & {1'b1, b[0]}, 1'b0});
         send(CMD_READ_FLAG, 1'b1);
         check({rsp.valid, rsp.data[7], ign}, {1'b1, ~b[0], 1'b0});
      end
      set_cfg(1'b0, 2'h2, 5'h04, 6'h00);
      send(CMD_READ_STATUS, 1'b1);
      check({rsp.valid, ign}, 2'b01);
      send(CMD_READ_FLAG, 1'b1);
      check({rsp.valid, ign}, 2'b01);
      set_cfg(1'b0, 2'h2, 5'h04, 6'h03);
      op_busy <= 1'b0;
      $display("test polling done");
   endtask
   task automatic t_susp;
      logic [7:0] c [4] = '{8'hB1, 8'hB2, 8'hB3, 8'hB4};
      logic [1:0] e [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
      op_busy <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         send(c[i], 1'b1);
         check({susp, psusp, write_in_progress_flag}, {e[i], ~|e[i]});
         rd_chk(32'hC, {26'h0, ~|e[i], 2'b00, e[i][0], e[i][1], 1'b1});
      end
      @(posedge ref_clk_i);
      op_busy <= 1'b0;
      $display("test suspend done");
   endtask
   task automatic t_pd;
      logic [1:0] us [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
      logic [4:0] cs [5] = '{5'h03, 5'h01, 5'h00, 5'h03, 5'h1F};
      int uc [4] = '{16, 125, 1000, U3};
      int k;
      int e0;
      for (int i = 0; i < 5; i++) begin
         set_cfg(1'b0, us[i], cs[i], 6'h03);
         rd_chk(32'h4, {1'b0, 8'hB5, 8'hB6, us[i], cs[i], 6'h03, 2'h0});
         send(8'hB5, 1'b1);
         check({pdn, ign}, 2'b10);
         send(CMD_READ_STATUS, 1'b1);
         check({rsp.valid, ign, pdn}, 3'b011);
         e0 = ex_cnt;
         send(8'hB6, 1'b1);
         check(exiting, 1'b1);
         send(CMD_READ_STATUS, 1'b0);
         check({rsp.valid, ign}, 2'b01);
         k = 0;
         while (exiting === 1'b1 && k < 3000) begin
            @(posedge ref_clk_i);
            k++;
         end
         #1;
         check(ex_cnt - e0, (int'(cs[i]) + 1) * uc[us[i]] + 1);
         check({pdn, exiting}, 2'b00);
      end
      $display("test power-down done");
   endtask
   task automatic t_unsup;
      set_cfg(1'b1, 2'h2, 5'h04, 6'h03);
      rd_chk(32'h4, {1'b1, 8'hB5, 8'hB6, 2'h2, 5'h04, 6'h03, 2'h0});
      send(8'hB5, 1'b1);
      check({pdn, ign}, 2'b01);
      set_cfg(1'b0, 2'h2, 5'h04, 6'h03);
      $display("test unsupported done");
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_codes();
      t_poll();
      t_susp();
      t_pd();
      t_unsup();
      give_verdict();
   end
   // the longest test needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      give_verdict();
   end
endmodule
